// *** rtl/gpio3_pkg.sv ***
/*
 * Constants shared by the three-port general-purpose I/O block:
 * bus widths, port widths, register offsets and reset values.
 * Assumes an 8-bit register port with byte offsets as listed here.
 */
`default_nettype none
package gpio3_pkg;
	localparam int          ADDR_W     = 8;                 // Register address width
	localparam int          DATA_W     = 8;                 // Register data width
	localparam int          PA_W       = 4;                 // First port pin count
	localparam int          PB_W       = 6;                 // Second port pin count
	localparam int          PC_W       = 2;                 // Third port pin count
	localparam int          CH_W       = 3;                 // Converter channel code width

	// Register offsets
	localparam logic [7:0]  OFS_DATA_A = 8'h00;             // First port data latch
	localparam logic [7:0]  OFS_DATA_B = 8'h01;             // Second port data latch
	localparam logic [7:0]  OFS_DATA_C = 8'h02;             // Third port data latch
	localparam logic [7:0]  OFS_DIR_A  = 8'h04;             // First port direction
	localparam logic [7:0]  OFS_DIR_B  = 8'h05;             // Second port direction
	localparam logic [7:0]  OFS_DIR_C  = 8'h06;             // Third port direction
	localparam logic [7:0]  OFS_PUE_A  = 8'h0C;             // First port pull-up enable
	localparam logic [7:0]  OFS_PUE_C  = 8'h0E;             // Third port pull-up enable
	localparam logic [7:0]  OFS_KBIE   = 8'h10;             // Keyboard pin interrupt enables

	// Reset values
	localparam logic [PA_W-1:0] DIR_A_RST = 4'h0;           // All inputs
	localparam logic [PB_W-1:0] DIR_B_RST = 6'h00;          // All inputs
	localparam logic [PC_W-1:0] DIR_C_RST = 2'h0;           // All inputs
	localparam logic [PA_W-1:0] PUE_A_RST = 4'h0;           // Pull-ups off
	localparam logic [PC_W-1:0] PUE_C_RST = 2'h0;           // Pull-ups off
	localparam logic [PA_W-1:0] KBIE_RST  = 4'h0;           // Keyboard pins off
	localparam logic [7:0]      RD_IDLE   = 8'h00;          // Read data outside a read
endpackage : gpio3_pkg
`default_nettype wire

// *** rtl/gpio3_port.sv ***
/*
 * Three-port general-purpose I/O block: data latches, direction,
 * pull-up enables, keyboard pin enables and converter override.
 * Assumes a single-cycle register port and pin inputs that are
 * already synchronous to i_ref_clk.
 * Data latches are not reset, so a pin turned into an output before
 * its latch is written drives an unknown level.
 */
`default_nettype none
module gpio3_port
	import gpio3_pkg::*;
(
	input  wire logic                        i_ref_clk,     // System clock
	input  wire logic                        i_rst_n,       // Async reset, active low
	input  wire logic [gpio3_pkg::ADDR_W-1:0] i_addr,       // Register address
	input  wire logic [gpio3_pkg::DATA_W-1:0] i_wdata,      // Write data
	input  wire logic                        i_wr,          // Write strobe
	input  wire logic                        i_rd,          // Read strobe
	output logic      [gpio3_pkg::DATA_W-1:0] o_rdata,      // Read data, cycle after strobe
	input  wire logic [gpio3_pkg::PA_W-1:0]  i_pa_in,       // First port pin levels
	output logic      [gpio3_pkg::PA_W-1:0]  o_pa_out,      // First port drive value
	output logic      [gpio3_pkg::PA_W-1:0]  o_pa_oe,       // First port driver enable
	output logic      [gpio3_pkg::PA_W-1:0]  o_pa_pu,       // First port pull-up on
	output logic      [gpio3_pkg::PA_W-1:0]  o_keyboard_inputs, // Enabled keyboard levels
	input  wire logic [gpio3_pkg::PB_W-1:0]  i_pb_in,       // Second port pin levels
	output logic      [gpio3_pkg::PB_W-1:0]  o_pb_out,      // Second port drive value
	output logic      [gpio3_pkg::PB_W-1:0]  o_pb_oe,       // Second port driver enable
	output logic      [gpio3_pkg::PB_W-1:0]  o_converter_channel_inputs, // Analog select
	input  wire logic                        i_conv_sel_valid, // Converter channel active
	input  wire logic [gpio3_pkg::CH_W-1:0]  i_conv_sel,    // Converter channel code
	input  wire logic [gpio3_pkg::PC_W-1:0]  i_pc_in,       // Third port pin levels
	output logic      [gpio3_pkg::PC_W-1:0]  o_pc_out,      // Third port drive value
	output logic      [gpio3_pkg::PC_W-1:0]  o_pc_oe,       // Third port driver enable
	output logic      [gpio3_pkg::PC_W-1:0]  o_pc_pu        // Third port pull-up on
);
	import gpio3_pkg::*;

	// Register state
	logic [PA_W-1:0]   latch_a_r, latch_a_nxt;
	logic [PB_W-1:0]   latch_b_r, latch_b_nxt;
	logic [PC_W-1:0]   latch_c_r, latch_c_nxt;
	logic [PA_W-1:0]   dir_a_r, dir_a_nxt;
	logic [PB_W-1:0]   dir_b_r, dir_b_nxt;
	logic [PC_W-1:0]   dir_c_r, dir_c_nxt;
	logic [PA_W-1:0]   pue_a_r, pue_a_nxt;
	logic [PC_W-1:0]   pue_c_r, pue_c_nxt;
	logic [PA_W-1:0]   kbie_r, kbie_nxt;
	logic [DATA_W-1:0] rdata_r, rdata_nxt;

	// Pin-level derived terms
	logic [PA_W-1:0]   drv_a;
	logic [PB_W-1:0]   ovr_b;
	logic [PB_W-1:0]   drv_b;
	logic [PA_W-1:0]   view_a;
	logic [PB_W-1:0]   view_b;
	logic [PC_W-1:0]   view_c;

	// Converter channel decode; out-of-range codes select nothing
	// A spare code therefore hands every second-port pin back to software
	// converter pin override
	always_comb begin
		ovr_b = '0;
		for (int i = 0; i < PB_W; i++) begin
			if (i_conv_sel_valid && (int'(i_conv_sel) == i)) begin
				ovr_b[i] = 1'b1;
			end
		end
	end

	assign drv_a = dir_a_r & ~kbie_r;
	assign drv_b = dir_b_r & ~ovr_b;

	// A double select would release two pins and muddle the analog input
	a_conv_onehot: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		$onehot0(o_converter_channel_inputs)
		&& (i_conv_sel_valid || o_converter_channel_inputs == '0))
		else $error("converter select not one-hot");

	// Readback view: latch where the direction bit is set (second port: driven pins only), pin level otherwise
	// latch readback on outputs
	assign view_a = (dir_a_r & latch_a_r) | (~dir_a_r & i_pa_in);
	assign view_b = (drv_b & latch_b_r) | (~drv_b & i_pb_in);
	assign view_c = (dir_c_r & latch_c_r) | (~dir_c_r & i_pc_in);

	// Second port falls back to the pin wherever the converter owns it
	a_read_port_b: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		(i_rd && i_addr == OFS_DATA_B) |=>
		o_rdata == DATA_W'(($past(dir_b_r & ~o_converter_channel_inputs) & $past(latch_b_r))
			| (~$past(dir_b_r & ~o_converter_channel_inputs) & $past(i_pb_in))))
		else $error("second port read mismatch");

	// A converter-owned pin reads its level whatever its direction bit
	a_conv_pin_read: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		(i_rd && i_addr == OFS_DATA_B && i_conv_sel_valid && (int'(i_conv_sel) < PB_W)) |=>
		o_rdata[$past(i_conv_sel)] == $past(i_pb_in[i_conv_sel]))
		else $error("converter pin read not from pin");

	// Next values of the writable registers
	// writes land regardless of direction
	always_comb begin
		latch_a_nxt = latch_a_r;
		latch_b_nxt = latch_b_r;
		latch_c_nxt = latch_c_r;
		dir_a_nxt   = dir_a_r;
		dir_b_nxt   = dir_b_r;
		dir_c_nxt   = dir_c_r;
		pue_a_nxt   = pue_a_r;
		pue_c_nxt   = pue_c_r;
		kbie_nxt    = kbie_r;
		if (i_wr) begin
			unique case (i_addr)
				OFS_DATA_A: latch_a_nxt = i_wdata[PA_W-1:0];
				OFS_DATA_B: latch_b_nxt = i_wdata[PB_W-1:0];
				OFS_DATA_C: latch_c_nxt = i_wdata[PC_W-1:0];
				OFS_DIR_A:  dir_a_nxt   = i_wdata[PA_W-1:0];
				OFS_DIR_B:  dir_b_nxt   = i_wdata[PB_W-1:0];
				OFS_DIR_C:  dir_c_nxt   = i_wdata[PC_W-1:0];
				OFS_PUE_A:  pue_a_nxt   = i_wdata[PA_W-1:0];
				OFS_PUE_C:  pue_c_nxt   = i_wdata[PC_W-1:0];
				OFS_KBIE:   kbie_nxt    = i_wdata[PA_W-1:0];
				default:    ;
			endcase
		end
	end

	// Writes reach the drive value even while the pin is an input
	a_latch_write_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		(i_wr && i_addr == OFS_DATA_A) |=> o_pa_out == $past(i_wdata[PA_W-1:0]))
		else $error("first port latch write lost");
	a_latch_write_b: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		(i_wr && i_addr == OFS_DATA_B) |=> o_pb_out == $past(i_wdata[PB_W-1:0]))
		else $error("second port latch write lost");
	a_latch_write_c: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		(i_wr && i_addr == OFS_DATA_C) |=> o_pc_out == $past(i_wdata[PC_W-1:0]))
		else $error("third port latch write lost");

	// Read mux; unmapped offsets and idle cycles return zero
	// upper bits read zero
	always_comb begin
		rdata_nxt = RD_IDLE;
		if (i_rd) begin
			unique case (i_addr)
				OFS_DATA_A: rdata_nxt = DATA_W'(view_a);
				OFS_DATA_B: rdata_nxt = DATA_W'(view_b);
				OFS_DATA_C: rdata_nxt = DATA_W'(view_c);
				OFS_DIR_A:  rdata_nxt = DATA_W'(dir_a_r);
				OFS_DIR_B:  rdata_nxt = DATA_W'(dir_b_r);
				OFS_DIR_C:  rdata_nxt = DATA_W'(dir_c_r);
				OFS_PUE_A:  rdata_nxt = DATA_W'(pue_a_r);
				OFS_PUE_C:  rdata_nxt = DATA_W'(pue_c_r);
				OFS_KBIE:   rdata_nxt = DATA_W'(kbie_r);
				default:    rdata_nxt = RD_IDLE;
			endcase
		end
	end

	// Unused bits read zero so software need not mask them
	a_upper_zero_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		(i_rd && i_addr == OFS_PUE_A) |=> o_rdata[DATA_W-1:PA_W] == '0)
		else $error("first port pull-up upper bits not zero");
	a_upper_zero_b: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		(i_rd && i_addr == OFS_DIR_B) |=> o_rdata[DATA_W-1:PB_W] == '0)
		else $error("second port direction upper bits not zero");

	// Data latches have no reset on purpose; they power up unknown
	// Software must fill a latch before raising its direction bit
	// latches survive reset
	always_ff @(posedge i_ref_clk) begin
		latch_a_r <= latch_a_nxt;
		latch_b_r <= latch_b_nxt;
		latch_c_r <= latch_c_nxt;
	end

	// Control registers and read data
	// One cycle of read latency keeps the decode off the bus return path
	// directions cleared on reset
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			dir_a_r <= DIR_A_RST;
			dir_b_r <= DIR_B_RST;
			dir_c_r <= DIR_C_RST;
			pue_a_r <= PUE_A_RST;
			pue_c_r <= PUE_C_RST;
			kbie_r  <= KBIE_RST;
			rdata_r <= RD_IDLE;
		end else begin
			dir_a_r <= dir_a_nxt;
			dir_b_r <= dir_b_nxt;
			dir_c_r <= dir_c_nxt;
			pue_a_r <= pue_a_nxt;
			pue_c_r <= pue_c_nxt;
			kbie_r  <= kbie_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// Pin outputs; drive values come straight from the latches
	// pins of all three ports
	assign o_pa_out = latch_a_r;
	assign o_pa_oe  = drv_a;
	assign o_pb_out = latch_b_r;
	assign o_pb_oe  = drv_b;
	assign o_pc_out = latch_c_r;
	assign o_pc_oe  = dir_c_r;

	// A direction write takes the driver on the very next cycle unless a keyboard enable or converter select masks the pin
	a_dir_enable_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		(i_wr && i_addr == OFS_DIR_A && kbie_r == KBIE_RST) |=>
		o_pa_oe == $past(i_wdata[PA_W-1:0]))
		else $error("first port driver enable wrong");
	a_dir_enable_b: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		(i_wr && i_addr == OFS_DIR_B) |=>
		(i_conv_sel_valid || o_pb_oe == $past(i_wdata[PB_W-1:0])))
		else $error("second port driver enable wrong");

	// Reset leaves every pin a quiet input with no pull-up
	a_rst_quiet: assert property (@(posedge i_ref_clk)
		!i_rst_n |-> (o_pa_pu == '0 && o_pc_pu == '0 && o_keyboard_inputs == '0))
		else $error("pull-up or keyboard pin active in reset");

	// Pull-ups drop out automatically while a pin drives
	// pull-up only on inputs
	assign o_pa_pu = pue_a_r & ~drv_a;
	assign o_pc_pu = pue_c_r & ~dir_c_r;

	// Enables apply on the next cycle, masked only where a pin drives
	a_pue_a_apply: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		(i_wr && i_addr == OFS_PUE_A) |=>
		o_pa_pu == ($past(i_wdata[PA_W-1:0]) & ~o_pa_oe))
		else $error("first port pull-up enable not applied");
	a_dir_c_pu_drop: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		(i_wr && i_addr == OFS_DIR_C) |=>
		(o_pc_pu & $past(i_wdata[PC_W-1:0])) == '0)
		else $error("third port pull-up left on a driver");

	// Keyboard levels gated by enables; second port has no pull-ups
	// Readback ignores the keyboard enable, so software still sees its latch
	// keyboard enable routing
	assign o_keyboard_inputs          = kbie_r & i_pa_in;
	assign o_converter_channel_inputs = ovr_b;
	assign o_rdata                    = rdata_r;

	// Enabling a keyboard pin releases its driver on the next cycle
	a_kbd_release: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		(i_wr && i_addr == OFS_KBIE) |=>
		(o_pa_oe & $past(i_wdata[PA_W-1:0])) == '0)
		else $error("keyboard pin still driven");

	// Checks on the register port and pin control
	a_read_port_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		(i_rd && i_addr == OFS_DATA_A) |=>
		o_rdata == DATA_W'(($past(dir_a_r) & $past(latch_a_r))
			| (~$past(dir_a_r) & $past(i_pa_in))))
		else $error("first port read mismatch");

	a_read_pin_c: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		(i_rd && i_addr == OFS_DATA_C && dir_c_r == DIR_C_RST) |=>
		o_rdata == DATA_W'($past(i_pc_in)))
		else $error("third port input read mismatch");

	a_write_keeps_pin: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		(i_wr && i_addr == OFS_DATA_B) ##1 (i_rd && i_addr == OFS_DATA_B) |=>
		o_rdata == DATA_W'(($past(i_wdata, 2) & $past(drv_b))
			| (~$past(drv_b) & $past(i_pb_in))))
		else $error("second port write/read mismatch");

	a_dir_enable: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		(i_wr && i_addr == OFS_DIR_C) |=> o_pc_oe == $past(i_wdata[PC_W-1:0]))
		else $error("third port driver enable wrong");

	a_reset_inputs: assert property (@(posedge i_ref_clk)
		!i_rst_n |-> (o_pa_oe == '0 && o_pb_oe == '0 && o_pc_oe == '0))
		else $error("driver enabled during reset");

	a_pullup_off: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		((o_pa_pu & o_pa_oe) == '0) && ((o_pc_pu & o_pc_oe) == '0))
		else $error("pull-up on a driving pin");

	a_pullup_on: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		(i_wr && i_addr == OFS_PUE_C && dir_c_r == DIR_C_RST) |=>
		o_pc_pu == $past(i_wdata[PC_W-1:0]))
		else $error("pull-up enable not applied");

	a_conv_override: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		i_conv_sel_valid && (int'(i_conv_sel) < PB_W) |->
		o_pb_oe[i_conv_sel] == 1'b0 && o_converter_channel_inputs[i_conv_sel])
		else $error("converter pin still driven");

	a_conv_digital: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		!i_conv_sel_valid |-> o_pb_oe == dir_b_r)
		else $error("second port drive altered without channel");

	a_upper_zero: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		(i_rd && i_addr == OFS_DIR_C) |=> o_rdata[DATA_W-1:PC_W] == '0)
		else $error("unused bits not zero");

	a_kbd_input: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		o_keyboard_inputs == (kbie_r & i_pa_in) && (o_pa_oe & kbie_r) == '0)
		else $error("keyboard pin not an input");

	a_idle_zero: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		!i_rd |=> o_rdata == RD_IDLE)
		else $error("read data outside read cycle");

	// Main scenarios
	c_out_readback: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		(i_wr && i_addr == OFS_DIR_A && i_wdata[0]) ##1 (i_rd && i_addr == OFS_DATA_A));
	c_conv_select: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		i_conv_sel_valid && dir_b_r != DIR_B_RST);
	c_pullup_act: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		o_pa_pu != '0 ##1 o_pa_pu == '0);
	c_back_to_back: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		(i_wr && i_addr == OFS_DATA_B) ##1 (i_rd && i_addr == OFS_DATA_B));
	c_kbd_forced: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		(kbie_r & dir_a_r) != '0);
endmodule : gpio3_port
`default_nettype wire

// *** dv/pin_model.sv ***
/*
 * Behavioural model of the pads and board outside one port.
 * Assumes at most one of block driver and outside driver is on.
 */
`default_nettype none
module pin_model #(
	parameter int W = 4                  // Pin count
) (
	input  wire logic         i_ref_clk, // Clock for float pattern
	input  wire logic [W-1:0] i_out,     // Block drive value
	input  wire logic [W-1:0] i_oe,      // Block drive enable
	input  wire logic [W-1:0] i_pu,      // Block pull-up on
	input  wire logic [W-1:0] i_ext,     // Outside drive value
	input  wire logic [W-1:0] i_ext_en,  // Outside drive enable
	output logic      [W-1:0] o_pin      // Resolved pin level
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [W-1:0] flt_r = '0;

	// Floating pins wander, so no read may rely on them
	always_ff @(posedge i_ref_clk) begin
		flt_r <= ~flt_r;
	end

	always_comb begin
		for (int k = 0; k < W; k++) begin
			o_pin[k] = i_oe[k] ? i_out[k] : i_ext_en[k] ? i_ext[k] : i_pu[k] ? 1'b1 : flt_r[k];
		end
	end
endmodule : pin_model
`default_nettype wire

// *** dv/tb.sv ***
/*
 * Self-checking bench for the three-port I/O block.
 * Assumes the register map and read latency of the package.
 */
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import gpio3_pkg::*;
	localparam logic [7:0] ofs_tab [8] = '{OFS_DIR_A, OFS_DIR_B, OFS_DIR_C, OFS_PUE_A,
		OFS_PUE_C, OFS_KBIE, 8'h03, 8'h1F};
	localparam logic [7:0] msk_tab [8] = '{8'h0F, 8'h3F, 8'h03, 8'h0F, 8'h03, 8'h0F, 8'h00, 8'h00};
	// Reset starts unknown so its fall at time zero fires the async clear
	logic       clk = 1'b0, rst_n, wr_s = 1'b0, rd_s = 1'b0, rd_d = 1'b0, cv_v = 1'b0;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, exq[$];
	logic [2:0] cv = 3'h0;
	logic [3:0] pa_in, pa_out, pa_oe, pa_pu, kbd, ea = 4'h0, ea_en = 4'h0, la, da, ua, kb;
	logic [5:0] pb_in, pb_out, pb_oe, cci, eb = 6'h00, eb_en = 6'h00, lb, db, sb;
	logic [1:0] pc_in, pc_out, pc_oe, pc_pu, ec = 2'h0, ec_en = 2'h0, lc, dc, uc;
	int         n_fail = 0, compares = 0;

	initial begin
		forever #2 clk = ~clk;
	end

	gpio3_port gpio3_port_i (.i_ref_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata),
		.i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata), .i_pa_in(pa_in), .o_pa_out(pa_out),
		.o_pa_oe(pa_oe), .o_pa_pu(pa_pu), .o_keyboard_inputs(kbd), .i_pb_in(pb_in),
		.o_pb_out(pb_out), .o_pb_oe(pb_oe), .o_converter_channel_inputs(cci),
		.i_conv_sel_valid(cv_v), .i_conv_sel(cv), .i_pc_in(pc_in), .o_pc_out(pc_out),
		.o_pc_oe(pc_oe), .o_pc_pu(pc_pu));
	pin_model #(.W(4)) pin_model_a_i (.i_ref_clk(clk), .i_out(pa_out), .i_oe(pa_oe),
		.i_pu(pa_pu), .i_ext(ea), .i_ext_en(ea_en), .o_pin(pa_in));
	pin_model #(.W(6)) pin_model_b_i (.i_ref_clk(clk), .i_out(pb_out), .i_oe(pb_oe),
		.i_pu(6'h00), .i_ext(eb), .i_ext_en(eb_en), .o_pin(pb_in));
	pin_model #(.W(2)) pin_model_c_i (.i_ref_clk(clk), .i_out(pc_out), .i_oe(pc_oe),
		.i_pu(pc_pu), .i_ext(ec), .i_ext_en(ec_en), .o_pin(pc_in));

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr_s  <= 1'b1;
		@(posedge clk);
		wr_s  <= 1'b0;
	endtask : wr

	// Expected read data is queued when the strobe goes out
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		exq.push_back(e);
		@(posedge clk);
		rd_s <= 1'b0;
	endtask : rd

	// Write then read the same address with no idle cycle between strobes
	task automatic wrrd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr_s  <= 1'b1;
		@(posedge clk);
		wr_s  <= 1'b0;
		rd_s  <= 1'b1;
		exq.push_back(e);
		@(posedge clk);
		rd_s  <= 1'b0;
	endtask : wrrd

	task automatic close_out();
		$display("Compares %0d, mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : close_out

	// Read data stands only in the cycle after the strobe
	always @(posedge clk) begin
		rd_d <= rd_s;
		if (rd_d && exq.size() > 0) chk(rdata, exq.pop_front());
	end

	initial begin
		rst_n <= 1'b0;
		void'($urandom(94));
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		// Reset values, then the width of every control register and two holes
		foreach (ofs_tab[k]) rd(ofs_tab[k], 8'h00);
		foreach (ofs_tab[k]) wr(ofs_tab[k], 8'hFF);
		foreach (ofs_tab[k]) rd(ofs_tab[k], msk_tab[k]);
		// Random setups, walking every converter code with and without valid
		for (int i = 0; i < 16; i++) begin
			{la, da, ua, kb} = 16'($urandom);
			{lb, db} = 12'($urandom);
			{lc, dc, uc} = 6'($urandom);
			sb = (i[0] && i[3:1] < 6) ? 6'(1 << i[3:1]) : 6'h00;
			wr(OFS_DATA_A, 8'(la));
			wr(OFS_DATA_B, 8'(lb));
			wr(OFS_DATA_C, 8'(lc));
			wr(OFS_DIR_A, 8'(da));
			wr(OFS_DIR_B, 8'(db));
			wr(OFS_DIR_C, 8'(dc));
			wr(OFS_PUE_A, 8'(ua));
			wr(OFS_PUE_C, 8'(uc));
			wr(OFS_KBIE, 8'(kb));
			cv_v  <= i[0];
			cv    <= 3'(i >> 1);
			ea    <= 4'($urandom);
			ea_en <= ~(da & ~kb);
			eb    <= 6'($urandom);
			eb_en <= ~(db & ~sb);
			ec    <= 2'($urandom);
			ec_en <= ~dc;
			@(negedge clk);
			chk(8'(pa_oe), 8'(da & ~kb));
			chk(8'(pa_pu), 8'(ua & ~(da & ~kb)));
			chk(8'(kbd), 8'(kb & ea));
			chk(8'(pb_oe), 8'(db & ~sb));
			chk(8'(cci), 8'(sb));
			chk(8'(pc_oe), 8'(dc));
			chk(8'(pc_pu), 8'(uc & ~dc));
			chk({pa_out, pc_out, 2'h0}, {la, lc, 2'h0});
			chk(8'(pb_out), 8'(lb));
			rd(OFS_DATA_A, 8'((la & da) | (ea & ~da)));
			rd(OFS_DATA_B, 8'((lb & db & ~sb) | (eb & ~(db & ~sb))));
			rd(OFS_DATA_C, 8'((lc & dc) | (ec & ~dc)));
			// Back-to-back write and read of port B, upper write bits set
			lb = ~lb;
			wrrd(OFS_DATA_B, {2'h3, lb}, 8'((lb & db & ~sb) | (eb & ~(db & ~sb))));
		end
		cv_v <= 1'b0;
		wr(OFS_DIR_B, 8'h30);
		wr(OFS_DIR_C, 8'h03);
		@(negedge clk);
		chk(8'(pb_oe), 8'h30);
		chk(8'(pc_pu), 8'h00);
		// Second reset clears drivers but keeps the latches
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (3) @(negedge clk);
		chk({pa_out, pc_out, pc_oe}, {la, lc, 2'h0});
		chk({pb_out, 2'h0}, {lb, 2'h0});
		chk(8'(pa_oe), 8'h00);
		@(posedge clk);
		rst_n <= 1'b1;
		rd(OFS_DIR_A, 8'h00);
		for (int k = 0; k < 10 && exq.size() > 0; k++) @(posedge clk);
		if (exq.size() > 0) n_fail++;
		close_out();
	end
endmodule : tb
`default_nettype wire
